// ---- ums_master_spi.sv ----
/*
 * Master SPI mode of the serial port: transmit buffer and shifter, receive
 * shifter feeding a two-level queue, baud generator and pin overrides.
 * Assumes control bits come from registers on clk_i and that the serial
 * input pin is asynchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module ums_master_spi
   import ums_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  resetn_i,
   input  wire ums_cfg_type           cfg_i,
   input  wire logic                  baud_wr_i,
   input  wire logic [UMS_BAUD_W-1:0] baud_wdata_i,
   input  wire logic                  data_wr_i,
   input  wire logic [UMS_DATA_W-1:0] data_wdata_i,
   input  wire logic                  data_rd_i,
   input  wire logic                  tx_complete_clear_i,
   input  wire logic                  serial_in_pin_i,
   output logic      [UMS_BAUD_W-1:0] baud_divisor_o,
   output logic      [UMS_DATA_W-1:0] data_rdata_o,
   output ums_status_type             status_o,
   output logic                       rx_irq_o,
   output logic                       tx_irq_o,
   output logic                       empty_irq_o,
   output logic                       serial_out_pin_o,
   output logic                       serial_out_pin_oe_o,
   output logic                       serial_clock_o,
   output logic                       serial_clock_oe_o,
   output logic                       serial_in_override_o
);

   // ---------------------------------------------------------------------
   // State
   // ---------------------------------------------------------------------
   logic [UMS_BAUD_W-1:0] baud_divisor;
   logic [UMS_BAUD_W-1:0] baud_cnt;
   logic [UMS_DATA_W-1:0] tx_buf;
   logic                  tx_buf_full;
   logic [UMS_DATA_W-1:0] tx_shift;
   logic [UMS_DATA_W-1:0] rx_shift;
   logic [4:0]            edge_cnt;
   logic                  busy;
   logic                  sck;
   logic                  mosi;
   logic                  tx_complete;
   logic                  in_meta;
   logic                  in_sync;

   // ---------------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------------
   wire spi_mode   = (cfg_i.mode_select_field == UMS_MODE_SPI);
   // The transmitter stays alive after disable until queued work drains.
   wire tx_active  = spi_mode && (cfg_i.tx_enable || busy || tx_buf_full);
   wire rx_active  = spi_mode && cfg_i.rx_enable;
   wire tick       = busy && (baud_cnt == '0);
   wire lead_edge  = tick && !edge_cnt[0];
   wire trail_edge = tick && edge_cnt[0];
   wire last_edge  = tick && (edge_cnt == UMS_LAST_EDGE);
   wire load_frame = spi_mode && !busy && tx_buf_full;
   wire sample_now = cfg_i.clock_phase ? trail_edge : lead_edge;
   wire change_now = cfg_i.clock_phase ? lead_edge : trail_edge;
   wire lsb_first  = cfg_i.bit_order_bit;
   wire tx_take    = data_wr_i && cfg_i.tx_enable && spi_mode && !tx_buf_full;

   // Next receive word: the incoming bit enters at the end the order sets.
   wire [UMS_DATA_W-1:0] rx_shifted = lsb_first ? {in_sync, rx_shift[UMS_DATA_W-1:1]}
                                                : {rx_shift[UMS_DATA_W-2:0], in_sync};
   wire [UMS_DATA_W-1:0] next_rx     = sample_now ? rx_shifted : rx_shift;
   // Next transmit word and the bit that leaves first.
   wire [UMS_DATA_W-1:0] tx_advanced = lsb_first ? {1'h0, tx_shift[UMS_DATA_W-1:1]}
                                                 : {tx_shift[UMS_DATA_W-2:0], 1'h0};
   wire first_bit_buf = lsb_first ? tx_buf[0] : tx_buf[UMS_DATA_W-1];
   wire next_bit_tx   = lsb_first ? tx_advanced[0] : tx_advanced[UMS_DATA_W-1];

   wire [UMS_DATA_W-1:0] rx_head;
   wire                  rx_empty;
   wire                  frame_push = last_edge && rx_active;

   // ---------------------------------------------------------------------
   // Serial input synchroniser
   // ---------------------------------------------------------------------
   // Two flops guard against metastability; the cost is two cycles of lag,
   // which limits how fast a slave may answer at the smallest divisors.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         in_meta <= 1'h0;
         in_sync <= 1'h0;
      end else begin
         in_meta <= serial_in_pin_i;
         in_sync <= in_meta;
      end
   end

   // ---------------------------------------------------------------------
   // Baud divisor and edge generator
   // ---------------------------------------------------------------------
   // The divisor clears at reset so an early write starts the clock at once.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         baud_divisor <= UMS_BAUD_RESET;
      end else if (baud_wr_i) begin
         baud_divisor <= baud_wdata_i;
      end
   end

   // One edge every divisor+1 cycles gives a rate of clk over 2(divisor+1).
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         baud_cnt <= '0;
      end else if (load_frame || tick || baud_wr_i) begin
         baud_cnt <= baud_wr_i ? baud_wdata_i : baud_divisor;
      end else if (busy) begin
         baud_cnt <= baud_cnt - 12'h001;
      end
   end

   // ---------------------------------------------------------------------
   // Transmit buffer
   // ---------------------------------------------------------------------
   // A write into a full buffer is dropped with no collision flag.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tx_buf      <= '0;
         tx_buf_full <= 1'h0;
      end else if (tx_take) begin
         tx_buf      <= data_wdata_i;
         tx_buf_full <= 1'h1;
      end else if (load_frame) begin
         tx_buf_full <= 1'h0;
      end
   end

   // ---------------------------------------------------------------------
   // Frame engine
   // ---------------------------------------------------------------------
   // Sixteen clock edges make one eight-bit frame; edges alternate leading
   // and trailing starting with a leading one.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         busy     <= 1'h0;
         edge_cnt <= '0;
         sck      <= 1'h0;
         tx_shift <= '0;
         rx_shift <= '0;
         mosi     <= UMS_IDLE_LINE;
      end else if (load_frame) begin
         busy     <= 1'h1;
         edge_cnt <= '0;
         sck      <= cfg_i.clock_polarity;
         tx_shift <= tx_buf;
         rx_shift <= '0;
         // Phase zero puts the first bit out before the leading edge.
         mosi     <= cfg_i.clock_phase ? mosi : first_bit_buf;
      end else if (tick) begin
         sck      <= ~sck;
         edge_cnt <= edge_cnt + 5'h01;
         rx_shift <= next_rx;
         if (change_now && !(cfg_i.clock_phase && edge_cnt == '0)) begin
            tx_shift <= tx_advanced;
            mosi     <= next_bit_tx;
         end else if (change_now) begin
            mosi     <= lsb_first ? tx_shift[0] : tx_shift[UMS_DATA_W-1];
         end
         if (last_edge) begin
            busy <= 1'h0;
            mosi <= UMS_IDLE_LINE;
         end
      end else if (!busy) begin
         sck  <= cfg_i.clock_polarity;
         mosi <= UMS_IDLE_LINE;
      end
   end

   // ---------------------------------------------------------------------
   // Transmit complete flag
   // ---------------------------------------------------------------------
   // A frame that ends in the clearing cycle still sets the flag.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tx_complete <= 1'h0;
      end else if (last_edge && !tx_buf_full) begin
         tx_complete <= 1'h1;
      end else if (tx_complete_clear_i) begin
         tx_complete <= 1'h0;
      end
   end

   // ---------------------------------------------------------------------
   // Receive queue and read data
   // ---------------------------------------------------------------------
   ums_rx_fifo u_rx_fifo (
      .clk_i       (clk_i),
      .resetn_i    (resetn_i),
      .flush_i     (!rx_active),
      .push_i      (frame_push),
      .push_data_i (next_rx),
      .pop_i       (data_rd_i),
      .head_o      (rx_head),
      .empty_o     (rx_empty)
   );

   // The read answer is held in a flop; it reads zero when nothing waits.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         data_rdata_o <= '0;
      end else if (data_rd_i) begin
         data_rdata_o <= rx_empty ? '0 : rx_head;
      end
   end

   // ---------------------------------------------------------------------
   // Status, interrupts and pins
   // ---------------------------------------------------------------------
   assign baud_divisor_o                  = baud_divisor;
   assign status_o.receive_complete_flag  = !rx_empty;
   assign status_o.transmit_complete_flag = tx_complete;
   assign status_o.buffer_empty_flag      = !tx_buf_full;
   assign status_o.framing_error_flag     = 1'h0;
   assign status_o.overrun_error_flag     = 1'h0;
   assign status_o.parity_error_flag      = 1'h0;
   assign rx_irq_o             = cfg_i.rx_irq_enable && !rx_empty;
   assign tx_irq_o             = cfg_i.tx_irq_enable && tx_complete;
   assign empty_irq_o          = cfg_i.empty_irq_enable && !tx_buf_full;
   // Master only: the clock is driven whenever the transmitter is active and no select pin exists.
   assign serial_out_pin_o     = mosi;
   assign serial_out_pin_oe_o  = tx_active;
   assign serial_clock_o       = sck;
   assign serial_clock_oe_o    = tx_active;
   assign serial_in_override_o = rx_active;

endmodule
`default_nettype wire

// ---- ums_master_spi_asserts.sv ----
/* Checker for the master SPI mode port, bound below its endmodule.
   Assumes the ports of ums_master_spi and one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module ums_master_spi_asserts
   import ums_pkg::*;
(
   input wire logic                  clk_i,
   input wire logic                  resetn_i,
   input wire ums_cfg_type           cfg_i,
   input wire logic                  baud_wr_i,
   input wire logic [UMS_BAUD_W-1:0] baud_wdata_i,
   input wire logic                  data_wr_i,
   input wire logic [UMS_BAUD_W-1:0] baud_divisor_o,
   input wire ums_status_type        status_o,
   input wire logic                  rx_irq_o,
   input wire logic                  tx_irq_o,
   input wire logic                  empty_irq_o,
   input wire logic                  serial_out_pin_oe_o,
   input wire logic                  serial_clock_o,
   input wire logic                  serial_clock_oe_o,
   input wire logic                  serial_in_override_o
);
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   wire         spi_on;
   logic [12:0] gap;
   assign spi_on = cfg_i.mode_select_field == UMS_MODE_SPI;
   // Cycles since the clock pin last moved; it saturates so idle time never wraps.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) gap <= 13'h1fff;
      else if ($changed(serial_clock_o)) gap <= 13'h0000;
      else if (gap != 13'h1fff) gap <= gap + 13'h0001;
   end
   // An accepted write: buffer free, mode and transmitter on.
   sequence s_take;
      data_wr_i && status_o.buffer_empty_flag && spi_on && cfg_i.tx_enable;
   endsequence
   a_err_flags_zero:
      assert property (!(status_o.framing_error_flag || status_o.overrun_error_flag
         || status_o.parity_error_flag)) else $error("error flag set");
   a_reset_values:
      assert property ($rose(resetn_i) |-> baud_divisor_o == UMS_BAUD_RESET
         && status_o == 6'h08) else $error("bad state after reset");
   a_baud_load:
      assert property (baud_wr_i |=> baud_divisor_o == $past(baud_wdata_i))
      else $error("divisor not loaded");
   a_tx_pin_owned:
      assert property (spi_on && cfg_i.tx_enable |-> serial_out_pin_oe_o
         && serial_clock_oe_o) else $error("transmit pins not owned");
   a_rx_pin_owned:
      assert property (serial_in_override_o == (spi_on && cfg_i.rx_enable))
      else $error("input pin override wrong");
   a_write_fills:
      assert property (s_take |=> !status_o.buffer_empty_flag)
      else $error("write did not fill buffer");
   a_tc_only_empty:
      assert property ($rose(status_o.transmit_complete_flag) |-> status_o.buffer_empty_flag)
      else $error("complete with data pending");
   a_irq_levels:
      assert property (rx_irq_o == (cfg_i.rx_irq_enable && status_o.receive_complete_flag)
         && tx_irq_o == (cfg_i.tx_irq_enable && status_o.transmit_complete_flag)
         && empty_irq_o == (cfg_i.empty_irq_enable && status_o.buffer_empty_flag))
      else $error("interrupt level wrong");
   a_clock_half:
      assert property ($changed(serial_clock_o) && gap != 13'h1fff |-> gap >= baud_divisor_o)
      else $error("clock half period short");
   a_rx_flush:
      assert property ($fell(cfg_i.rx_enable) |-> ##[1:2] !status_o.receive_complete_flag)
      else $error("queue not flushed");
endmodule
bind ums_master_spi ums_master_spi_asserts ums_master_spi_asserts_inst (
   .clk_i, .resetn_i, .cfg_i, .baud_wr_i, .baud_wdata_i, .data_wr_i, .baud_divisor_o,
   .status_o, .rx_irq_o, .tx_irq_o, .empty_irq_o, .serial_out_pin_oe_o, .serial_clock_o,
   .serial_clock_oe_o, .serial_in_override_o);
`default_nettype wire

// ---- ums_master_spi_tb_top.sv ----
/* Self-checking bench for the master SPI mode port with an echoing slave.
   Assumes the checker binds itself from its own file. */
`timescale 1ns/1ps
`default_nettype none
module ums_master_spi_tb_top
   import ums_pkg::*;
;
   localparam logic [11:0] DIV   = 12'h004;
   localparam logic [7:0]  FIRST = 8'h5c;
   logic           clk_i, resetn_i, baud_wr, data_wr, data_rd, tc_clr, miso;
   ums_cfg_type    cfg;
   logic [11:0]    baud_wdata, baud;
   logic [7:0]     wdata, rdata, heard, prev;
   ums_status_type st;
   logic           rx_irq, tx_irq, empty_irq, mosi, mosi_oe, sck, sck_oe, in_ovr;
   int             error_cnt, samples_checked;
   ums_master_spi ums_master_spi_inst (.clk_i(clk_i), .resetn_i(resetn_i), .cfg_i(cfg),
      .baud_wr_i(baud_wr), .baud_wdata_i(baud_wdata), .data_wr_i(data_wr),
      .data_wdata_i(wdata), .data_rd_i(data_rd), .tx_complete_clear_i(tc_clr),
      .serial_in_pin_i(miso), .baud_divisor_o(baud), .data_rdata_o(rdata), .status_o(st),
      .rx_irq_o(rx_irq), .tx_irq_o(tx_irq), .empty_irq_o(empty_irq), .serial_out_pin_o(mosi),
      .serial_out_pin_oe_o(mosi_oe), .serial_clock_o(sck), .serial_clock_oe_o(sck_oe),
      .serial_in_override_o(in_ovr));
   ums_spi_slave_model #(.FIRST_BYTE(FIRST)) ums_spi_slave_model_inst (.clk_i(clk_i),
      .sck_i(sck), .mosi_i(mosi), .cpol_i(cfg.clock_polarity), .cpha_i(cfg.clock_phase),
      .lsb_first_i(cfg.bit_order_bit), .miso_o(miso), .heard_o(heard));
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [11:0] got, input logic [11:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask
   // A wait that ran out of cycles is a mismatch, never a silent fall-through.
   task automatic limit_chk(input int n, input int max);
      if (n > max) begin
         error_cnt++;
         $display("[FAIL] %0t ns: wait limit %0d ran out", $time, max);
      end
   endtask
   // Waits for a free buffer first; a full buffer would silently drop the byte.
   task automatic wr(input logic [7:0] b);
      int n = 0;
      @(posedge clk_i);
      while (st.buffer_empty_flag !== 1'b1 && n++ < 500) @(posedge clk_i);
      limit_chk(n, 500);
      data_wr <= 1'b1;
      wdata   <= b;
      @(posedge clk_i);
      data_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] exp);
      @(posedge clk_i);
      data_rd <= 1'b1;
      @(posedge clk_i);
      data_rd <= 1'b0;
      @(posedge clk_i);
      check(rdata, exp);
   endtask
   task automatic clear_tc;
      @(posedge clk_i);
      tc_clr <= 1'b1;
      @(posedge clk_i);
      tc_clr <= 1'b0;
   endtask
   // One full-duplex byte: measures a clock half period, then checks both directions.
   task automatic xfer(input logic [7:0] b);
      int n = 0;
      clear_tc();
      wr(b);
      while (sck !== cfg.clock_polarity && n++ < 100) @(posedge clk_i);
      while (sck === cfg.clock_polarity && n++ < 200) @(posedge clk_i);
      limit_chk(n, 200);
      n = 0;
      @(posedge clk_i);
      while (sck !== cfg.clock_polarity && n++ < 100) @(posedge clk_i);
      check(12'(n), DIV);
      while (st.receive_complete_flag !== 1'b1 && n++ < 400) @(posedge clk_i);
      limit_chk(n, 400);
      @(posedge clk_i);
      check(heard, b);
      check({rx_irq, tx_irq, empty_irq, st.transmit_complete_flag}, 4'hf);
      check({mosi, sck}, {1'b1, cfg.clock_polarity});
      rd(prev);
      prev = b;
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic refuse;
      for (int m = 0; m < 3; m++) begin
         @(posedge clk_i);
         cfg.mode_select_field <= 2'(m);
         repeat (2) @(posedge clk_i);
         check({mosi_oe, sck_oe, in_ovr}, 3'h0);
         wr(8'h0f);
         repeat (30) @(posedge clk_i);
         check({st.buffer_empty_flag, sck}, 2'h2);
      end
      cfg.mode_select_field <= UMS_MODE_SPI;
      $display("refuse test done");
   endtask
   task automatic modes;
      for (int m = 0; m < 8; m++) begin
         @(posedge clk_i);
         cfg.clock_polarity <= m[0];
         cfg.clock_phase    <= m[1];
         cfg.bit_order_bit  <= m[2];
         repeat (3) @(posedge clk_i);
         xfer(8'h96 ^ 8'(m * 37));
      end
      $display("modes test done");
   endtask
   // Three queued bytes with no reads: the third answer is dropped, older ones kept.
   task automatic overflow;
      int n = 0;
      clear_tc();
      wr(8'h11);
      wr(8'h22);
      @(posedge clk_i);
      check(st.buffer_empty_flag, 1'b0);
      wr(8'h33);
      while (st.transmit_complete_flag !== 1'b1 && n++ < 800) @(posedge clk_i);
      limit_chk(n, 800);
      repeat (2) @(posedge clk_i);
      rd(prev);
      rd(8'h11);
      rd(8'h00);
      check(st.receive_complete_flag, 1'b0);
      wr(8'h44);
      while (st.receive_complete_flag !== 1'b1 && n++ < 1200) @(posedge clk_i);
      limit_chk(n, 1200);
      cfg.rx_enable <= 1'b0;
      repeat (3) @(posedge clk_i);
      check({st.receive_complete_flag, rx_irq}, 2'h0);
      cfg.rx_enable <= 1'b1;
      prev = 8'h44;
      $display("overflow test done");
   endtask
   task automatic results;
      $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Clock and watchdog; the whole run needs well under three thousand cycles.
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      $display("[FAIL] %0t ns: watchdog expired", $time);
      results();
   end
   // Reset, initialisation in the documented order, then the scenarios.
   initial begin
      {resetn_i, baud_wr, data_wr, data_rd, tc_clr} = 5'h00;
      {baud_wdata, wdata, cfg} = '0;
      {error_cnt, samples_checked} = '0;
      prev = FIRST;
      repeat (8) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      check(baud, 12'h000);
      check({st, mosi}, 7'h11);
      cfg <= '{UMS_MODE_SPI, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
      @(posedge clk_i);
      {cfg.tx_enable, cfg.rx_enable} <= 2'h3;
      @(posedge clk_i);
      baud_wr    <= 1'b1;
      baud_wdata <= DIV;
      @(posedge clk_i);
      baud_wr <= 1'b0;
      @(posedge clk_i);
      check(baud, DIV);
      refuse();
      modes();
      overflow();
      results();
   end
endmodule
`default_nettype wire

// ---- ums_pkg.sv ----
/*
 * Shared constants and carrier types of the master-only SPI mode of the
 * serial port: mode encodings, frame length, field widths and the packed
 * configuration and status bundles.
 * Assumes it is compiled before every module that imports it.
 */
// Behaviour
// - Baud divisor resets to zero.
// - Transmit enable turns output pin into serial out.
// - Receive enable turns input pin into serial in.
// - Clock pin carries transfer clock whenever transmitter runs.
// - Only a data write starts a transfer.
// - Buffered byte moves to shifter when it frees.
// - On overflow keep old bytes, drop newest.
// - Receive, transmit and empty flags behave normally.
// - Frame, overrun and parity flags read zero.
// - Double buffered transmit, two-level receive buffer.
// - Polarity, phase, order act as standard SPI.
// - No collision detection; no double-speed control.
// - Master only, no slave-select function.
// - Mode field value three selects master SPI.
// - Eight-bit frames, selectable order, idle line high.
// - Clock rate is system clock over 2(divisor+1).
// - Phase zero samples leading edge; other edge changes.
`default_nettype none
package ums_pkg;

   // ---------------------------------------------------------------------
   // Widths and encodings
   // ---------------------------------------------------------------------
   localparam int          UMS_DATA_W     = 8;
   localparam int          UMS_BAUD_W     = 12;
   localparam int          UMS_RX_DEPTH   = 2;
   localparam logic [1:0]  UMS_MODE_SPI   = 2'h3;
   localparam logic [11:0] UMS_BAUD_RESET = 12'h000;
   localparam logic [4:0]  UMS_LAST_EDGE  = 5'h0f;   // Sixteen edges per frame.
   localparam logic        UMS_IDLE_LINE  = 1'h1;

   // Configuration bits that software holds in its control registers.
   typedef struct packed {
      logic [1:0] mode_select_field;
      logic       tx_enable;
      logic       rx_enable;
      logic       bit_order_bit;   // One sends the least significant bit first.
      logic       clock_phase;
      logic       clock_polarity;
      logic       rx_irq_enable;
      logic       tx_irq_enable;
      logic       empty_irq_enable;
   } ums_cfg_type;

   // Status flags as software reads them.
   typedef struct packed {
      logic receive_complete_flag;
      logic transmit_complete_flag;
      logic buffer_empty_flag;
      logic framing_error_flag;
      logic overrun_error_flag;
      logic parity_error_flag;
   } ums_status_type;

endpackage
`default_nettype wire

// ---- ums_rx_fifo.sv ----
/*
 * Small receive queue holding completed bytes until software reads them.
 * Assumes a single clock; push and pop come from logic on that clock.
 */
`timescale 1ns/1ps
`default_nettype none
module ums_rx_fifo
   import ums_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  resetn_i,
   input  wire logic                  flush_i,
   input  wire logic                  push_i,
   input  wire logic [UMS_DATA_W-1:0] push_data_i,
   input  wire logic                  pop_i,
   output logic      [UMS_DATA_W-1:0] head_o,
   output logic                       empty_o
);

   logic [UMS_DATA_W-1:0] mem [UMS_RX_DEPTH];
   logic [1:0]            count;
   logic                  rd_ptr;
   logic                  wr_ptr;
   wire                   full     = (count == 2'(UMS_RX_DEPTH));
   wire                   do_pop   = pop_i && (count != 2'h0);
   wire                   do_push  = push_i && !full;   // A byte into a full queue is lost.

   assign head_o  = mem[rd_ptr];
   assign empty_o = (count == 2'h0);

   // -------------------------------------------------------------------
   // Pointers and occupancy
   // -------------------------------------------------------------------
   // Flush wins over everything so a disabled receiver shows no data after its first disabled cycle.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         count  <= 2'h0;
         rd_ptr <= 1'h0;
         wr_ptr <= 1'h0;
      end else if (flush_i) begin
         count  <= 2'h0;
         rd_ptr <= 1'h0;
         wr_ptr <= 1'h0;
      end else begin
         if (do_push) wr_ptr <= ~wr_ptr;
         if (do_pop)  rd_ptr <= ~rd_ptr;
         count <= count + 2'(do_push) - 2'(do_pop);
      end
   end

   // Storage needs no reset; occupancy says which entries hold data.
   always_ff @(posedge clk_i) begin
      if (do_push) mem[wr_ptr] <= push_data_i;
   end

endmodule
`default_nettype wire

// ---- ums_spi_slave_model.sv ----
/* Behavioural SPI slave that answers each frame with the byte it heard last.
   Assumes its pins move only on the system clock it is given. */
`timescale 1ns/1ps
`default_nettype none
module ums_spi_slave_model #(
   parameter logic [7:0] FIRST_BYTE = 8'h5c
) (
   input  wire logic       clk_i,
   input  wire logic       sck_i,
   input  wire logic       mosi_i,
   input  wire logic       cpol_i,
   input  wire logic       cpha_i,
   input  wire logic       lsb_first_i,
   output logic            miso_o,
   output logic      [7:0] heard_o
);
   logic [3:0] edge_cnt = 4'h0;
   logic [7:0] shift = 8'h00;
   logic [7:0] next_shift;
   logic       sck_q = 1'b0;
   logic       mosi_q = 1'b1;
   wire  [3:0] pos_cnt;
   wire  [2:0] bit_idx;
   initial heard_o = FIRST_BYTE;
   // In phase one the bit only moves on leading edges, so the position lags one edge.
   assign pos_cnt = (cpha_i && edge_cnt != 4'h0) ? edge_cnt - 4'h1 : edge_cnt;
   assign bit_idx = lsb_first_i ? pos_cnt[3:1] : 3'h7 - pos_cnt[3:1];
   assign miso_o  = heard_o[bit_idx];
   // Edges are seen one cycle late, with data as it stood before the edge, like a real setup.
   always @(posedge clk_i) begin
      next_shift = shift;
      if (sck_i !== sck_q && (sck_i !== cpol_i || edge_cnt[0])) begin
         if (edge_cnt[0] == cpha_i)
            next_shift = lsb_first_i ? {mosi_q, shift[7:1]} : {shift[6:0], mosi_q};
         if (edge_cnt == 4'hf)
            heard_o <= next_shift;
         edge_cnt <= edge_cnt + 4'h1;
      end
      shift  <= next_shift;
      sck_q  <= sck_i;
      mosi_q <= mosi_i;
   end
endmodule
`default_nettype wire
